// [rtl/dss_consts.vh]
// constants and overview for the display switch-off sequencer
// Overview of operation
// [R1] A standby command waits for the current vertical scan, then the vertical flyback, to end before slow stop starts.
// [R2] Slow stop ramps the horizontal on-time from nominal down to zero over about 50 ms.
// [R3] On the standby path with fixed beam enabled, the discharge beam current starts together with slow stop.
// [R4] The discharge beam current lasts 18.6 ms or 25 ms as the duration select bit chooses.
// [R5] During either switch-off path overscan hold parks the vertical deflection, otherwise it keeps running.
// [R6] After a standby stop has begun the mains-loss input is ignored.
// [R7] The external supply monitor raises the mains-loss input when the line deflection supply drops.
// [R8] On mains loss, after scan and flyback end, the beam current is forced if enabled while horizontal drive runs.
// [R9] Power-on-reset stops both the horizontal output and the discharge beam current.
// [R10] Slow stop is aligned to the start of the first new vertical field after the scan and flyback end.
// [R11] With fixed beam enable clear no discharge beam current is ever forced; other steps are unchanged.
`ifndef DSS_CONSTS_VH
`define DSS_CONSTS_VH
`define DSS_CLK_MHZ        100
`define DSS_SLOW_STOP_MS   50
`define DSS_BEAM_SHORT_US  18600
`define DSS_BEAM_LONG_US   25000
`define DSS_SLOW_STOP_CYC  (`DSS_SLOW_STOP_MS * 1000 * `DSS_CLK_MHZ)
`define DSS_BEAM_SHORT_CYC (`DSS_BEAM_SHORT_US * `DSS_CLK_MHZ)
`define DSS_BEAM_LONG_CYC  (`DSS_BEAM_LONG_US * `DSS_CLK_MHZ)
`define DSS_ADDR_CTRL      2'h0
`define DSS_ADDR_STAT      2'h1
`define DSS_ADDR_ONTIME    2'h2
`define DSS_CTRL_FBE       0
`define DSS_CTRL_OSH       1
`define DSS_CTRL_DUR       2
`define DSS_CTRL_STBY      3
`define DSS_CTRL_RST       8'h00
`define DSS_ONTIME_MAX     8'hFF
`endif

// [rtl/dss_sync2.v]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dss_sync2 (
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_d,
  output wire o_q
);
  reg s1_ff;
  reg s2_ff;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
    end else begin
      s1_ff <= i_d;
      s2_ff <= s1_ff;
    end
  end
  assign o_q = s2_ff;
endmodule // dss_sync2

// [rtl/dss_seq.v]
// switch-off sequencer: standby slow stop and mains-loss beam discharge
`timescale 1ns/1ps
`include "dss_consts.vh"
module dss_seq #(
  parameter SLOW_STOP_CYC  = `DSS_SLOW_STOP_CYC,
  parameter BEAM_SHORT_CYC = `DSS_BEAM_SHORT_CYC,
  parameter BEAM_LONG_CYC  = `DSS_BEAM_LONG_CYC
) (
  input  wire       i_clk,
  input  wire       i_rst_n,
  input  wire [1:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  input  wire       i_vscan_end,
  input  wire       i_vflyback_end,
  input  wire       i_field_start,
  input  wire       i_mains_loss_input,
  input  wire       i_por,
  output wire [7:0] o_h_ontime,
  output wire       o_h_drive_en,
  output wire       o_fixed_beam,
  output wire       o_overscan_hold,
  output wire       o_switch_off_active
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_SCAN  = 3'h1;
  localparam ST_FLYB  = 3'h2;
  localparam ST_FIELD = 3'h3;
  localparam ST_SLOW  = 3'h4;
  localparam ST_OFF   = 3'h5;
  localparam ST_MAINS = 3'h6;
  localparam ST_MHOLD = 3'h7;
  // ramp runs from full on-time down to zero in equal steps
  localparam STEP_CYC = SLOW_STOP_CYC / `DSS_ONTIME_MAX;

  wire       mains_s;
  reg  [7:0] ctrl_ff;
  reg  [2:0] st_ff;
  reg  [2:0] nxt_st;
  reg        path_mains_ff;
  reg        nxt_path_mains;
  reg  [7:0] ontime_ff;
  reg  [7:0] nxt_ontime;
  reg  [23:0] step_ff;
  reg  [23:0] nxt_step;
  reg  [23:0] beam_cnt_ff;
  reg  [23:0] nxt_beam_cnt;
  reg        beam_ff;
  reg        nxt_beam;
  reg        hdrv_ff;
  reg        nxt_hdrv;
  reg        stby_seen_ff;
  reg        nxt_stby_seen;
  wire [23:0] beam_len;
  wire        stby_req;
  wire        ctrl_wr;
  wire        ovs_bit;
  wire        nxt_active;
  wire        nxt_ovs;
  reg         active_ff;
  reg         ovs_ff;

  dss_sync2 u_mains_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     (i_mains_loss_input),
    .o_q     (mains_s)
  );

  assign stby_req = i_wr && (i_addr == `DSS_ADDR_CTRL) && i_wdata[`DSS_CTRL_STBY];
  // duration latched from config when beam starts is not needed: bit is static in practice
  assign beam_len = ctrl_ff[`DSS_CTRL_DUR] ? BEAM_LONG_CYC[23:0] : BEAM_SHORT_CYC[23:0]; // R4
  assign ctrl_wr  = i_wr && (i_addr == `DSS_ADDR_CTRL);

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_ff <= `DSS_CTRL_RST;
    end else if (i_wr && (i_addr == `DSS_ADDR_CTRL)) begin
      ctrl_ff <= {5'h00, i_wdata[2:0]};
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `DSS_ADDR_CTRL:   o_rdata <= ctrl_ff;
        `DSS_ADDR_STAT:   o_rdata <= {hdrv_ff, beam_ff, stby_seen_ff, path_mains_ff, 1'b0, st_ff};
        `DSS_ADDR_ONTIME: o_rdata <= ontime_ff;
        default:          o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  always @* begin
    nxt_st         = st_ff;
    nxt_path_mains = path_mains_ff;
    nxt_ontime     = ontime_ff;
    nxt_step       = step_ff;
    nxt_beam       = beam_ff;
    nxt_beam_cnt   = beam_cnt_ff;
    nxt_hdrv       = hdrv_ff;
    nxt_stby_seen  = stby_seen_ff;
    if (beam_ff) begin
      if (beam_cnt_ff >= beam_len - 24'h000001) begin
        nxt_beam = 1'b0; // R4
      end else begin
        nxt_beam_cnt = beam_cnt_ff + 24'h000001;
      end
    end
    case (st_ff)
      ST_IDLE: begin
        if (stby_req) begin
          nxt_st        = ST_SCAN; // R1
          nxt_stby_seen = 1'b1;
        end else if (mains_s && !stby_seen_ff) begin // R6
          nxt_st         = ST_SCAN; // R8
          nxt_path_mains = 1'b1;
        end
      end
      ST_SCAN: begin
        if (i_vscan_end) begin
          nxt_st = ST_FLYB; // R1 R8
        end
      end
      ST_FLYB: begin
        if (i_vflyback_end) begin
          nxt_st = path_mains_ff ? ST_MAINS : ST_FIELD;
        end
      end
      ST_FIELD: begin
        if (i_field_start) begin // R10
          nxt_st   = ST_SLOW; // R2
          nxt_step = 24'h000000;
          if (ctrl_ff[`DSS_CTRL_FBE]) begin // R3 R11
            nxt_beam     = 1'b1;
            nxt_beam_cnt = 24'h000000;
          end
        end
      end
      ST_SLOW: begin
        if (step_ff >= STEP_CYC[23:0] - 24'h000001) begin
          nxt_step = 24'h000000;
          if (ontime_ff == 8'h01) begin
            nxt_ontime = 8'h00;
            nxt_hdrv   = 1'b0;
            nxt_st     = ST_OFF;
          end else begin
            nxt_ontime = ontime_ff - 8'h01; // R2
          end
        end else begin
          nxt_step = step_ff + 24'h000001;
        end
      end
      ST_OFF: begin
        nxt_st = ST_OFF;
      end
      ST_MAINS: begin
        if (ctrl_ff[`DSS_CTRL_FBE]) begin // R8 R11
          nxt_beam     = 1'b1;
          nxt_beam_cnt = 24'h000000;
        end
        nxt_st = ST_MHOLD;
      end
      ST_MHOLD: begin
        // horizontal drive keeps running until supply falls or a standby request starts the slow stop
        if (stby_req) begin
          nxt_st         = ST_SCAN;
          nxt_path_mains = 1'b0;
          nxt_stby_seen  = 1'b1;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff         <= ST_IDLE;
      path_mains_ff <= 1'b0;
      ontime_ff     <= `DSS_ONTIME_MAX;
      step_ff       <= 24'h000000;
      beam_ff       <= 1'b0;
      beam_cnt_ff   <= 24'h000000;
      hdrv_ff       <= 1'b1;
      stby_seen_ff  <= 1'b0;
    end else if (i_por) begin
      // supply below por level: everything stops and stays stopped
      st_ff     <= ST_OFF;
      beam_ff   <= 1'b0; // R9
      hdrv_ff   <= 1'b0; // R9
      ontime_ff <= 8'h00;
    end else begin
      st_ff         <= nxt_st;
      path_mains_ff <= nxt_path_mains;
      ontime_ff     <= nxt_ontime;
      step_ff       <= nxt_step;
      beam_ff       <= nxt_beam;
      beam_cnt_ff   <= nxt_beam_cnt;
      hdrv_ff       <= nxt_hdrv;
      stby_seen_ff  <= nxt_stby_seen;
    end
  end

  assign o_h_ontime          = ontime_ff;
  assign o_h_drive_en        = hdrv_ff;
  assign o_fixed_beam        = beam_ff;
  // flags taken from next state so they stay aligned with st_ff and ctrl_ff
  // while still coming straight from flip-flops
  assign ovs_bit    = ctrl_wr ? i_wdata[`DSS_CTRL_OSH] : ctrl_ff[`DSS_CTRL_OSH];
  assign nxt_active = i_por || (nxt_st != ST_IDLE);
  assign nxt_ovs    = ovs_bit && nxt_active; // R5

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      active_ff <= 1'b0;
      ovs_ff    <= 1'b0;
    end else begin
      active_ff <= nxt_active;
      ovs_ff    <= nxt_ovs; // R5
    end
  end

  assign o_switch_off_active = active_ff;
  assign o_overscan_hold     = ovs_ff; // R5
endmodule // dss_seq

// [testbench/dss_chk_assertions.sv]
// assertions on the switch-off sequencer ports
`timescale 1ns/1ps
module dss_chk #(
  parameter BEAM_SHORT_CYC = 300,
  parameter BEAM_LONG_CYC  = 400
) (
  input wire       i_clk,
  input wire       i_rst_n,
  input wire       i_rd,
  input wire       i_vflyback_end,
  input wire       i_field_start,
  input wire       i_por,
  input wire [7:0] o_rdata,
  input wire [7:0] o_h_ontime,
  input wire       o_h_drive_en,
  input wire       o_fixed_beam,
  input wire       o_overscan_hold,
  input wire       o_switch_off_active
);
  reg [31:0] beam_cnt_ff;
  always @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n) beam_cnt_ff <= 32'h0;
    else beam_cnt_ff <= o_fixed_beam ? beam_cnt_ff + 32'h1 : 32'h0;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_POR_STOP: assert property (i_por ##1 i_por |-> !o_h_drive_en && !o_fixed_beam)
    else $error("drive or beam still on under power-on-reset");
  AST_RAMP_DOWN: assert property (o_h_ontime <= $past(o_h_ontime))
    else $error("on-time rose");
  AST_RAMP_STEP: assert property (!$past(i_por) && $changed(o_h_ontime)
    |-> o_h_ontime == $past(o_h_ontime) - 8'h01) else $error("on-time step not one");
  AST_ZERO_STOP: assert property (o_h_ontime == 8'h00 |-> ##[0:2] !o_h_drive_en)
    else $error("drive runs at zero on-time");
  AST_DRIVE_FALL: assert property ($fell(o_h_drive_en) |-> o_h_ontime == 8'h00 || $past(i_por))
    else $error("drive stopped early");
  AST_OVERSCAN: assert property (o_overscan_hold |-> o_switch_off_active)
    else $error("overscan hold outside switch-off");
  AST_BEAM_START: assert property ($rose(o_fixed_beam) |-> $past(i_field_start)
    || $past(i_field_start, 2) || $past(i_vflyback_end, 2) || $past(i_vflyback_end, 3))
    else $error("beam start not aligned to field or flyback");
  AST_BEAM_LEN: assert property ($fell(o_fixed_beam) && !i_por && !$past(i_por)
    |-> beam_cnt_ff == BEAM_SHORT_CYC || beam_cnt_ff == BEAM_LONG_CYC)
    else $error("beam duration wrong");
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  cover property ($rose(o_fixed_beam));
  cover property ($fell(o_h_drive_en));
  cover property (o_overscan_hold);
endmodule // dss_chk
bind dss_seq dss_chk #(.BEAM_SHORT_CYC(BEAM_SHORT_CYC), .BEAM_LONG_CYC(BEAM_LONG_CYC)) u_chk (.*);

// [testbench/dss_vgen.sv]
// vertical timing and supply monitor model
`timescale 1ns/1ps
module dss_vgen (
  input  wire i_clk,
  input  wire i_supply_drop,
  output reg  o_vscan_end,
  output reg  o_vflyback_end,
  output reg  o_field_start,
  output reg  o_mains_loss
);
  reg [5:0] line_ff;
  initial {line_ff, o_vscan_end, o_vflyback_end, o_field_start, o_mains_loss} = 10'h000;
  always @(posedge i_clk) begin
    line_ff        <= line_ff + 6'h01;
    o_vscan_end    <= line_ff == 6'h28;
    o_vflyback_end <= line_ff == 6'h32;
    o_field_start  <= line_ff == 6'h3F;
    o_mains_loss   <= i_supply_drop;
  end
endmodule // dss_vgen

// [testbench/tb_dss_seq.sv]
// self-checking bench for the switch-off sequencer
`timescale 1ns/1ps
module tb_dss_seq;
  reg        i_clk, i_rst_n, i_wr, i_rd, i_por, drop;
  reg  [1:0] i_addr;
  reg  [7:0] i_wdata;
  reg [31:0] r;
  wire [7:0] o_rdata, o_h_ontime;
  wire       i_vscan_end, i_vflyback_end, i_field_start, i_mains_loss_input;
  wire       o_h_drive_en, o_fixed_beam, o_overscan_hold, o_switch_off_active;
  integer    fail_count, num_checks, seed, i, k, bc, os;
  // short counts keep each run to a few thousand cycles
  localparam BEAM_S = 300;
  localparam BEAM_L = 400;
  dss_seq #(.SLOW_STOP_CYC(2550), .BEAM_SHORT_CYC(BEAM_S), .BEAM_LONG_CYC(BEAM_L)) dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_vscan_end(i_vscan_end),
    .i_vflyback_end(i_vflyback_end), .i_field_start(i_field_start),
    .i_mains_loss_input(i_mains_loss_input), .i_por(i_por), .o_h_ontime(o_h_ontime),
    .o_h_drive_en(o_h_drive_en), .o_fixed_beam(o_fixed_beam),
    .o_overscan_hold(o_overscan_hold), .o_switch_off_active(o_switch_off_active));
  dss_vgen u_vgen (.i_clk(i_clk), .i_supply_drop(drop), .o_vscan_end(i_vscan_end),
    .o_vflyback_end(i_vflyback_end), .o_field_start(i_field_start),
    .o_mains_loss(i_mains_loss_input));
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %s exp %0h seen %0h", nm, exp, seen);
      end
    end
  endtask
  // beam cycles owed by a configuration: none unless enabled, else the selected length
  function [31:0] exp_beam(input [2:0] cfg);
    exp_beam = cfg[0] ? (cfg[2] ? BEAM_L : BEAM_S) : 0;
  endfunction
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task do_reset;
    begin
      i_rst_n <= 1'b0;
      drop <= 1'b0;
      i_por <= 1'b0;
      repeat (10) @(posedge i_clk);
      i_rst_n <= 1'b1;
    end
  endtask
  task bus(input rd, input [1:0] a, input [7:0] d);
    begin
      @(posedge i_clk);
      i_rd <= rd;
      i_wr <= !rd;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_rd <= 1'b0;
      i_wr <= 1'b0;
      #1;
    end
  endtask
  // late supply drop on the standby path must not start the beam
  task run_test(input [2:0] cfg, input stby);
    begin
      do_reset;
      bus(1'b0, 2'h0, {4'h0, stby, cfg});
      bc = 0;
      os = 0;
      for (i = 0; i < 3200; i = i + 1) begin
        @(posedge i_clk);
        drop <= stby ? (i >= 3000) : 1'b1;
        #1;
        bc = bc + o_fixed_beam;
        os = os | o_overscan_hold;
      end
      chk("beam_cycles", bc, exp_beam(cfg));
      chk("overscan", os, cfg[1]);
      chk("ontime", o_h_ontime, stby ? 8'h00 : 8'hFF);
      chk("drive", o_h_drive_en, !stby);
      chk("active", o_switch_off_active, 1);
      bus(1'b1, 2'h1, 8'h00);
      chk("stat_drive", o_rdata[7], !stby);
      bus(1'b1, 2'h2, 8'h00);
      chk("rd_ontime", o_rdata, stby ? 8'h00 : 8'hFF);
      bus(1'b1, 2'h0, 8'h00);
      chk("rd_ctrl", o_rdata, cfg);
      $display("test cfg %0h standby %0d done", cfg, stby);
    end
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #600000;
    fail_count = fail_count + 1;
    give_verdict;
  end
  initial begin
    {i_rst_n, i_wr, i_rd, i_por, drop, i_addr, i_wdata} = 0;
    fail_count = 0;
    num_checks = 0;
    seed = 98;
    for (k = 0; k < 8; k = k + 1) run_test(k[2:0], 1'b1);
    run_test(3'h5, 1'b0);
    for (k = 0; k < 3; k = k + 1) begin
      r = $random(seed);
      run_test(r[2:0], 1'b0);
    end
    do_reset;
    bus(1'b1, 2'h3, 8'h00);
    chk("unmapped", o_rdata, 8'h00);
    bus(1'b0, 2'h0, 8'h01);
    drop <= 1'b1;
    for (i = 0; i < 200 && o_fixed_beam !== 1'b1; i = i + 1) begin
      @(posedge i_clk);
      #1;
    end
    chk("beam_on", o_fixed_beam, 1);
    // standby issued while the mains path holds must still run the slow stop
    bus(1'b0, 2'h0, 8'h09);
    for (i = 0; i < 300 && o_h_ontime === 8'hFF; i = i + 1) begin
      @(posedge i_clk);
      #1;
    end
    chk("mains_then_stby", o_h_ontime < 8'hFF, 1);
    chk("drive_mains", o_h_drive_en, 1);
    i_por <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    chk("por_stop", {o_h_drive_en, o_fixed_beam}, 0);
    $display("test power-on-reset done");
    give_verdict;
  end
endmodule // tb_dss_seq
